/* File: design/kbh_pkg.sv */
// Purpose: Shared constants and types for the keyboard handshake link
// Assumes: 10 MHz system clock
// Notes:   Timeout count is derived from its time in milliseconds
package kbh_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned TIMEOUT_MS  = 250;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / MS_PER_S);
  localparam int          TMR_W       = 22;

  // ********************************************************
  // Word framing
  // ********************************************************
  localparam int          DATA_W     = 8;
  localparam int          FIFO_DEPTH = 16;
  localparam int          IDX_W      = 4;
  localparam logic [3:0]  FIRST_IDX  = 4'h0;
  localparam logic [3:0]  STOP_IDX   = 4'h8;
  localparam logic        LINE_IDLE  = 1'b1;
  localparam logic        STOP_LEVEL = 1'b0;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic       closed;
    logic [6:0] key;
  } kbh_event_type;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_WAIT_FALL,
    S_WAIT_RISE,
    S_RESTART
  } kbh_phase_type;

  typedef struct packed {
    kbh_phase_type          st;
    logic [IDX_W-1:0]       idx;
    logic [DATA_W-1:0]      word;
    logic [TMR_W-1:0]       timer;
    logic                   ready;
    logic                   serial;
    logic                   ack_meta;
    logic                   ack_sync;
    logic                   ack_last;
  } kbh_state_type;

endpackage

/* File: design/kbh_fifo.sv */
// Purpose: Event queue between key scanning and the serial link
// Assumes: Single clock, synchronous active-high reset
// Notes:   Enable low freezes all state
`timescale 1ns/100ps
module kbh_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock, reset and enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_en,
  // Fill side
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  input  wire logic [W-1:0] i_wr_data,
  // Drain side
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready,
  output logic [W-1:0]      o_rd_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } kbh_fifo_state_type;

  kbh_fifo_state_type r_reg;
  kbh_fifo_state_type r_next;
  logic               push;
  logic               pop;

  assign o_wr_ready = (r_reg.cnt != (AW+1)'(D));
  assign o_rd_valid = (r_reg.cnt != '0);
  assign o_rd_data  = r_reg.mem[r_reg.rp];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = i_wr_data;
      r_next.wp            = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else if (i_en) begin
      r_reg <= r_next;
    end
  end

endmodule

/* File: design/kbh_link.sv */
// Purpose: Keyboard side of the ready/acknowledge serial key event link
// Assumes: Host acknowledge arrives asynchronously; events come from scan logic
// Notes:   Idle leaves both link lines high
`timescale 1ns/100ps
module kbh_link
  import kbh_pkg::*;
#(
  parameter int unsigned P_TIMEOUT_CYC = kbh_pkg::TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_SYS_RST,
  input  wire logic                   I_CLK_EN,
  // Key events from scanning
  input  wire logic                   I_EVT_VALID,
  input  wire kbh_pkg::kbh_event_type I_EVT,
  output logic                        O_EVT_READY,
  // Link pins
  input  wire logic                   I_HOST_ACK_LINE,
  output logic                        O_KBD_READY_STROBE,
  output logic                        O_KBD_SERIAL_LINE
);
  import kbh_pkg::*;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic bit_of(input logic [DATA_W-1:0] w, input logic [IDX_W-1:0] i);
    bit_of = (i == STOP_IDX) ? STOP_LEVEL : w[i[2:0]];
  endfunction

  // ********************************************************
  // Event queue
  // ********************************************************
  kbh_state_type       s_reg;
  kbh_state_type       s_next;
  logic                q_valid;
  logic                q_pop;
  logic [DATA_W-1:0]   q_data;
  logic                ack_fall;
  logic                ack_rise;
  logic                timeout;

  kbh_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_SYS_RST),
    .i_en       (I_CLK_EN),
    .i_wr_valid (I_EVT_VALID),
    .o_wr_ready (O_EVT_READY),
    .i_wr_data  ({I_EVT.closed, I_EVT.key}),
    .o_rd_valid (q_valid),
    .i_rd_ready (q_pop),
    .o_rd_data  (q_data)
  );

  assign q_pop    = (s_reg.st == S_IDLE);
  assign ack_fall = s_reg.ack_last && !s_reg.ack_sync;
  assign ack_rise = !s_reg.ack_last && s_reg.ack_sync;
  assign timeout  = (s_reg.timer == TMR_W'(P_TIMEOUT_CYC - 1));

  assign O_KBD_READY_STROBE = s_reg.ready;
  assign O_KBD_SERIAL_LINE  = s_reg.serial;

  // ********************************************************
  // Handshake sequencer
  // ********************************************************
  always_comb begin
    s_next          = s_reg;
    s_next.ack_meta = I_HOST_ACK_LINE;
    s_next.ack_sync = s_reg.ack_meta;
    s_next.ack_last = s_reg.ack_sync;
    case (s_reg.st)
      S_IDLE: begin
        if (q_valid) begin
          s_next.word   = q_data;
          s_next.idx    = FIRST_IDX;
          s_next.serial = bit_of(q_data, FIRST_IDX);
          s_next.st     = S_SETUP;
        end
      end
      S_SETUP: begin
        s_next.ready = 1'b0;
        s_next.timer = '0;
        s_next.st    = S_WAIT_FALL;
      end
      S_WAIT_FALL: begin
        s_next.timer = s_reg.timer + 1'b1;
        if (ack_fall) begin
          s_next.ready = 1'b1;
          if (s_reg.idx == STOP_IDX) begin
            s_next.serial = LINE_IDLE;
          end
          s_next.st = S_WAIT_RISE;
        end else if (timeout) begin
          s_next.ready = 1'b1;
          s_next.st    = S_RESTART;
        end
      end
      S_WAIT_RISE: begin
        if (ack_rise) begin
          if (s_reg.idx == STOP_IDX) begin
            s_next.st = S_IDLE;
          end else begin
            s_next.idx    = s_reg.idx + 1'b1;
            s_next.serial = bit_of(s_reg.word, s_reg.idx + 1'b1);
            s_next.st     = S_SETUP;
          end
        end
      end
      S_RESTART: begin
        s_next.idx    = FIRST_IDX;
        s_next.serial = bit_of(s_reg.word, FIRST_IDX);
        s_next.st     = S_SETUP;
      end
      default: begin
        s_next.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      s_reg          <= '0;
      s_reg.st       <= S_IDLE;
      s_reg.ready    <= LINE_IDLE;
      s_reg.serial   <= LINE_IDLE;
      s_reg.ack_meta <= LINE_IDLE;
      s_reg.ack_sync <= LINE_IDLE;
      s_reg.ack_last <= LINE_IDLE;
    end else if (I_CLK_EN) begin
      s_reg <= s_next;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);

  a_ready_low_start: assert property (
    (I_CLK_EN && s_reg.st == S_SETUP) |=> !O_KBD_READY_STROBE && s_reg.st == S_WAIT_FALL)
    else $error("ready not pulled low after bit setup");

  a_ready_up_fall: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_FALL && ack_fall) |=> O_KBD_READY_STROBE && s_reg.st == S_WAIT_RISE)
    else $error("ready not raised after acknowledge fall");

  a_data_change_cause: assert property (
    $changed(O_KBD_SERIAL_LINE) |->
      ($past(s_reg.st) == S_WAIT_RISE && $past(ack_rise)) || $past(s_reg.st) == S_IDLE ||
      $past(s_reg.st) == S_RESTART || ($past(s_reg.st) == S_WAIT_FALL && $past(s_reg.idx) == STOP_IDX))
    else $error("serial line changed without cause");

  a_data_at_drop: assert property (
    $fell(O_KBD_READY_STROBE) |-> O_KBD_SERIAL_LINE == bit_of(s_reg.word, s_reg.idx))
    else $error("bit value not present at ready fall");

  a_stop_low: assert property (
    ($fell(O_KBD_READY_STROBE) && s_reg.idx == STOP_IDX) |-> !O_KBD_SERIAL_LINE)
    else $error("stop bit not low at ready fall");

  a_stop_release: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_FALL && s_reg.idx == STOP_IDX && ack_fall)
      |=> O_KBD_READY_STROBE && O_KBD_SERIAL_LINE)
    else $error("stop bit release missing");

  a_stop_idle: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_RISE && s_reg.idx == STOP_IDX && ack_rise) |=> s_reg.st == S_IDLE)
    else $error("link not idle after stop acknowledge");

  a_bit_count: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_RISE && ack_rise && s_reg.idx != STOP_IDX)
      |=> s_reg.idx == $past(s_reg.idx) + 1'b1 && s_reg.idx <= STOP_IDX)
    else $error("bit index did not advance by one");

  a_word_load: assert property (
    (I_CLK_EN && s_reg.st == S_IDLE && q_valid) |=> s_reg.word == $past(q_data))
    else $error("event byte not loaded");

  a_timeout_restart: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_FALL && !ack_fall && timeout)
      |=> O_KBD_READY_STROBE && s_reg.st == S_RESTART)
    else $error("timeout did not restart transmission");

  a_data_stable: assert property (
    (!O_KBD_READY_STROBE && !$past(O_KBD_READY_STROBE)) |-> $stable(O_KBD_SERIAL_LINE))
    else $error("serial changed while ready low");

  a_idle_lines: assert property (
    (s_reg.st == S_IDLE) |-> O_KBD_READY_STROBE && O_KBD_SERIAL_LINE)
    else $error("link lines not high while idle");

  a_ready_hold: assert property (
    (I_CLK_EN && s_reg.st == S_WAIT_FALL && !ack_fall && !timeout)
      |=> !O_KBD_READY_STROBE && s_reg.st == S_WAIT_FALL)
    else $error("ready left low phase without cause");

  a_restart_first: assert property (
    (I_CLK_EN && s_reg.st == S_RESTART)
      |=> s_reg.idx == FIRST_IDX && O_KBD_SERIAL_LINE == bit_of(s_reg.word, FIRST_IDX) && s_reg.st == S_SETUP)
    else $error("restart did not resend from first bit");

  c_word_done:  cover property (s_reg.st == S_WAIT_RISE && s_reg.idx == STOP_IDX && ack_rise && I_CLK_EN);
  c_timeout:    cover property (s_reg.st == S_RESTART);
  c_queue_full: cover property (!O_EVT_READY);
  c_stop_release: cover property (s_reg.st == S_WAIT_FALL && s_reg.idx == STOP_IDX && ack_fall && I_CLK_EN);

endmodule

/* File: test/kbh_host_model.sv */
// Purpose: Host end of the key event link
// Assumes: Ack follows ready i_delay+1 cycles after ready changes
// Notes:   Mute stops all answers
`timescale 1ns/100ps
module kbh_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_mute,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_ready,
  input  wire logic       i_serial,
  output logic            o_ack,
  output logic            o_word_v,
  output logic [8:0]      o_word,
  output logic            o_stop_hi,
  output logic            o_bad
);
  logic [3:0] cnt;
  logic [3:0] idx;
  logic       rdy_q;
  logic       ser_q;
  always_ff @(posedge i_clk) begin
    o_word_v <= 1'b0;
    o_bad    <= 1'b0;
    rdy_q    <= i_ready;
    ser_q    <= i_serial;
    if (i_rst) begin
      o_ack <= 1'b1;
      cnt   <= 4'h0;
      idx   <= 4'h0;
      rdy_q <= 1'b1;
    end else begin
      if (i_mute || o_ack == i_ready) begin
        cnt <= 4'h0;
      end else if (cnt >= i_delay) begin
        o_ack <= i_ready;
        cnt   <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
      // Bit taken when ready falls
      if (rdy_q && !i_ready) begin
        o_word[idx] <= i_serial;
        idx         <= idx + 4'h1;
      end
      if (!rdy_q && i_ready) begin
        if (o_ack) begin
          idx <= 4'h0;
        end else if (idx == 4'h9) begin
          o_word_v  <= 1'b1;
          o_stop_hi <= i_serial;
          idx       <= 4'h0;
        end
      end
      if (!rdy_q && !i_ready && ser_q != i_serial) begin
        o_bad <= 1'b1;
      end
    end
  end
endmodule

/* File: test/tb_kbh_link.sv */
// Purpose: Self-checking bench for the key event link
// Assumes: Host model answers at a random pace
// Notes:   Timeout shortened to 50 cycles
`timescale 1ns/100ps
module tb_kbh_link;
  import kbh_pkg::*;
  localparam int TO = 50;
  logic          clk, rst, en, ev_v, ack, rdy, ser, evr, mute, wv, shi, bad;
  kbh_event_type ev;
  logic [3:0]    dly;
  logic [8:0]    w;
  logic [7:0]    q[$];
  int            errors, n_compared, n, i;
  bit            took, en_rand;
  kbh_link #(.P_TIMEOUT_CYC(TO)) dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CLK_EN(en),
    .I_EVT_VALID(ev_v), .I_EVT(ev), .O_EVT_READY(evr), .I_HOST_ACK_LINE(ack),
    .O_KBD_READY_STROBE(rdy), .O_KBD_SERIAL_LINE(ser));
  kbh_host_model host (.i_clk(clk), .i_rst(rst), .i_mute(mute), .i_delay(dly), .i_ready(rdy),
    .i_serial(ser), .o_ack(ack), .o_word_v(wv), .o_word(w), .o_stop_hi(shi), .o_bad(bad));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) en <= en_rand ? ($urandom % 8 != 0) : 1'b1;
  task automatic cmp_word(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic g);
    cmp_word(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic send(kbh_event_type e, int lim);
    ev_v <= 1'b1;
    ev   <= e;
    took = 0;
    for (int k = 0; k < lim && !took; k++) begin
      #1 took = evr && en;
      @(negedge clk);
    end
    if (took) q.push_back(e);
  endtask
  task automatic drain;
    for (int k = 0; k < 20000 && (q.size() > 0 || !ack); k++) @(negedge clk);
    cmp_bit("drain", 1'b1, q.size() == 0 && ack);
    if (q.size() != 0 || !ack) close_out();
  endtask
  // ********************************************************
  // Received word check
  // ********************************************************
  always @(negedge clk) begin
    if (wv) begin
      if (q.size() == 0) cmp_bit("extra word", 1'b0, 1'b1);
      else cmp_word("word", q.pop_front(), w[7:0]);
      cmp_bit("stop low", 1'b0, w[8]);
      cmp_bit("stop high", 1'b1, shi);
    end
    if (bad) cmp_bit("serial stable", 1'b0, 1'b1);
  end
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    rst  <= 1'b1;
    ev_v <= 1'b0;
    ev   <= '0;
    mute <= 1'b0;
    dly  <= 4'h0;
    en_rand = 0;
    errors = 0;
    n_compared = 0;
    void'($urandom(32'hce96));
    repeat (5) @(negedge clk);
    cmp_bit("idle ready", 1'b1, rdy);
    cmp_bit("idle serial", 1'b1, ser);
    rst <= 1'b0;
    // Back to back events, random pace and enable gaps
    en_rand = 1;
    for (i = 0; i < 22; i++) begin
      dly <= 4'($urandom % 7);
      if (i == 0) send('{1'b1, 7'h7f}, 1000);
      else if (i == 1) send('{1'b0, 7'h00}, 1000);
      else send(8'($urandom), 1000);
      cmp_bit("accept", 1'b1, took);
    end
    ev_v <= 1'b0;
    drain();
    en_rand = 0;
    // Silent host: ready must give up and restart
    mute <= 1'b1;
    send(8'($urandom), 40);
    ev_v <= 1'b0;
    for (n = 0; n < 100 && rdy; n++) @(negedge clk);
    cmp_bit("ready drop", 1'b0, rdy);
    if (rdy) close_out();
    for (n = 0; n < 200 && !rdy; n++) @(negedge clk);
    cmp_bit("timeout", 1'b1, n >= TO && n <= TO + 3);
    if (!rdy) close_out();
    mute <= 1'b0;
    drain();
    // Fill queue while host stalls
    mute <= 1'b1;
    n = 0;
    for (i = 0; i < 20; i++) begin
      send(8'($urandom), 3);
      if (took) n++;
    end
    ev_v <= 1'b0;
    cmp_word("fill", 8'h11, 8'(n));
    cmp_bit("full", 1'b0, evr);
    mute <= 1'b0;
    dly  <= 4'h5;
    drain();
    cmp_bit("empty", 1'b1, evr);
    close_out();
  end
endmodule
